/* hdl/idc_top.sv */
/*
  Legacy I/O decode, PCI interrupt steering and general chip select.
  Assumes APB from software, one I/O cycle description per mclk from the
  PCI target logic, and PCI interrupt lines synchronous to mclk.
*/
// Our own choice: the APB slave port.
module idc_top (
  // Clock and reset
  input  wire  logic                                mclk,
  input  wire  logic                                reset,
  // APB slave
  input  wire  logic                                psel,
  input  wire  logic                                penable,
  input  wire  logic                                pwrite,
  input  wire  logic [11:0]                         paddr,
  input  wire  logic [31:0]                         pwdata,
  input  wire  logic [3:0]                          pstrb,
  output logic       [31:0]                         prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // Cycle to decode
  input  wire  logic                                io_valid,
  input  wire  logic                                io_write,
  input  wire  logic [15:0]                         io_addr,
  input  wire  logic                                rom_space_hit,
  input  wire  logic                                keyboard_positive,
  // Decode answer
  output logic                                      claim_positive,
  output logic                                      claim_subtractive,
  output logic                                      isa_forward,
  output logic                                      disk_primary_hit,
  output logic                                      disk_secondary_hit,
  output logic                                      disk_primary_enable,
  output logic                                      disk_secondary_enable,
  output logic                                      general_chip_select_n,
  // Interrupts
  input  wire  logic [idc_pkg::NUM_PCI_INT-1:0]     pci_int_n,
  output logic       [idc_pkg::NUM_ISA_IRQ-1:0]     isa_irq
);

  idc_pkg::idc_state_t                       st;
  idc_pkg::idc_state_t                       next_st;
  logic [idc_pkg::NUM_ISA_IRQ-1:0]           line_irq [idc_pkg::NUM_PCI_INT];
  logic [idc_pkg::NUM_PCI_INT*idc_pkg::STEER_W-1:0] steer_fields;

  assign steer_fields = {st.regs.pci_irq_steering_two, st.regs.pci_irq_steering_one};

  // Each PCI line drives at most one IRQ through its steering field; off and reserved codes drive none
  genvar gi;
  generate
    for (gi = 0; gi < idc_pkg::NUM_PCI_INT; gi++) begin : g_steer
      logic [idc_pkg::STEER_W-1:0] code;
      assign code = steer_fields[gi*idc_pkg::STEER_W +: idc_pkg::STEER_W];
      always_comb begin
        line_irq[gi] = '0;
        if (!pci_int_n[gi] && code != idc_pkg::STEER_OFF && code != idc_pkg::STEER_RSVD_A &&
            code != idc_pkg::STEER_RSVD_B && code != idc_pkg::STEER_RSVD_C) begin
          line_irq[gi][code] = 1'b1;
        end
      end
    end
  endgenerate

  logic        setup_phase;
  logic        access_phase;
  logic [9:0]  word_idx;
  logic        mapped;
  logic        in_kbd;
  logic        in_dsec;
  logic        in_dpri;
  logic        in_par3;
  logic        in_par2;
  logic        in_par1;
  logic        cs_window;
  logic [15:0] cs_mask;
  logic [7:0]  dc2;
  logic [7:0]  csc;

  always_comb begin
    next_st      = st;
    dc2          = st.regs.decode_control_two;
    csc          = st.regs.chip_select_control;
    setup_phase  = psel && !penable;
    access_phase = psel && penable;
    word_idx     = paddr[11:2];
    mapped       = (word_idx == {2'b00, idc_pkg::IDX_DECODE_CONTROL_TWO})  ||
                   (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_ONE})   ||
                   (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_TWO})   ||
                   (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_BASE})    ||
                   (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_CONTROL});

    // Read data is captured in the setup phase so it stands in the access phase
    if (setup_phase) begin
      next_st.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (word_idx == {2'b00, idc_pkg::IDX_DECODE_CONTROL_TWO}) begin
          next_st.prdata[7:0] = dc2;
        end else if (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_ONE}) begin
          next_st.prdata[7:0] = st.regs.pci_irq_steering_one;
        end else if (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_TWO}) begin
          next_st.prdata[7:0] = st.regs.pci_irq_steering_two;
        end else if (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_BASE}) begin
          next_st.prdata[15:0] = st.regs.chip_select_base_address;
        end else if (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_CONTROL}) begin
          next_st.prdata[7:0] = csc;
        end
      end
    end

    // Writes take effect at the access edge, byte lane 0 and 1 only
    if (access_phase && pwrite) begin
      if (word_idx == {2'b00, idc_pkg::IDX_DECODE_CONTROL_TWO} && pstrb[0]) begin
        next_st.regs.decode_control_two = pwdata[7:0] & idc_pkg::DC2_WRITE_MASK;
      end
      if (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_ONE} && pstrb[0]) begin
        next_st.regs.pci_irq_steering_one = pwdata[7:0];
      end
      if (word_idx == {2'b00, idc_pkg::IDX_PCI_IRQ_STEER_TWO} && pstrb[0]) begin
        next_st.regs.pci_irq_steering_two = pwdata[7:0];
      end
      if (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_BASE}) begin
        if (pstrb[0]) begin
          next_st.regs.chip_select_base_address[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          next_st.regs.chip_select_base_address[15:8] = pwdata[15:8];
        end
      end
      if (word_idx == {2'b00, idc_pkg::IDX_CHIP_SELECT_CONTROL} && pstrb[0]) begin
        next_st.regs.chip_select_control = pwdata[7:0];
      end
    end

    // Legacy range hits
    in_kbd  = dc2[idc_pkg::DC2_KBD_ALT] &&
              (io_addr == idc_pkg::KBD_ALT_DATA || io_addr == idc_pkg::KBD_ALT_CMD);
    in_dsec = (io_addr >= idc_pkg::DSEC_LO && io_addr <= idc_pkg::DSEC_HI) ||
              io_addr == idc_pkg::DSEC_CTL;
    in_dpri = (io_addr >= idc_pkg::DPRI_LO && io_addr <= idc_pkg::DPRI_HI) ||
              io_addr == idc_pkg::DPRI_CTL;
    // The 7BCh, 678h and 778h aliases are never listed, so they fall to subtractive
    in_par3 = io_addr >= idc_pkg::PAR3_LO && io_addr <= idc_pkg::PAR3_HI;
    in_par2 = io_addr >= idc_pkg::PAR2_LO && io_addr <= idc_pkg::PAR2_HI;
    in_par1 = io_addr >= idc_pkg::PAR1_LO && io_addr <= idc_pkg::PAR1_HI;

    // Chip select window: size field masks low address bits
    cs_mask   = {11'h000, csc[idc_pkg::CSC_RANGE_HI:0]};
    cs_window = (io_addr & ~cs_mask) ==
                (st.regs.chip_select_base_address & ~cs_mask);

    next_st.dec = '0;
    next_st.dec.general_chip_select_n = 1'b1;
    if (io_valid) begin
      if (rom_space_hit) begin
        next_st.dec.claim_positive = dc2[idc_pkg::DC2_ROM_POS];
        next_st.dec.isa_forward    = 1'b1;
      end else if (in_dpri) begin
        next_st.dec.claim_positive   = dc2[idc_pkg::DC2_DISK_PRI];
        next_st.dec.disk_primary_hit = dc2[idc_pkg::DC2_DISK_PRI];
        next_st.dec.isa_forward      = !dc2[idc_pkg::DC2_DISK_PRI];
      end else if (in_dsec) begin
        next_st.dec.claim_positive     = dc2[idc_pkg::DC2_DISK_SEC];
        next_st.dec.disk_secondary_hit = dc2[idc_pkg::DC2_DISK_SEC];
        next_st.dec.isa_forward        = !dc2[idc_pkg::DC2_DISK_SEC];
      end else if (in_kbd) begin
        next_st.dec.claim_positive = keyboard_positive;
        next_st.dec.isa_forward    = 1'b1;
      end else if (in_par3) begin
        next_st.dec.claim_positive = dc2[idc_pkg::DC2_PAR_THREE];
        next_st.dec.isa_forward    = 1'b1;
      end else if (in_par2) begin
        next_st.dec.claim_positive = dc2[idc_pkg::DC2_PAR_TWO];
        next_st.dec.isa_forward    = 1'b1;
      end else if (in_par1) begin
        next_st.dec.claim_positive = dc2[idc_pkg::DC2_PAR_ONE];
        next_st.dec.isa_forward    = 1'b1;
      end else begin
        next_st.dec.isa_forward = 1'b1;
      end
      next_st.dec.claim_subtractive = !next_st.dec.claim_positive;
      if (!rom_space_hit && csc[idc_pkg::CSC_ENABLE] && cs_window &&
          ((io_write && csc[idc_pkg::CSC_WRITE_EN]) ||
           (!io_write && csc[idc_pkg::CSC_READ_EN]))) begin
        next_st.dec.general_chip_select_n = 1'b0;
      end
    end

    next_st.isa_irq = '0;
    for (int i = 0; i < idc_pkg::NUM_PCI_INT; i++) begin
      next_st.isa_irq = next_st.isa_irq | line_irq[i];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st                               <= '0;
      st.regs.decode_control_two       <= idc_pkg::RST_DECODE_CONTROL_TWO;
      st.regs.pci_irq_steering_one     <= idc_pkg::RST_PCI_IRQ_STEER;
      st.regs.pci_irq_steering_two     <= idc_pkg::RST_PCI_IRQ_STEER;
      st.regs.chip_select_base_address <= idc_pkg::RST_CHIP_SELECT_BASE;
      st.regs.chip_select_control      <= idc_pkg::RST_CHIP_SELECT_CONTROL;
      st.dec.general_chip_select_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.prdata;

  assign claim_positive        = st.dec.claim_positive;
  assign claim_subtractive     = st.dec.claim_subtractive;
  assign isa_forward           = st.dec.isa_forward;
  assign disk_primary_hit      = st.dec.disk_primary_hit;
  assign disk_secondary_hit    = st.dec.disk_secondary_hit;
  assign disk_primary_enable   = st.regs.decode_control_two[idc_pkg::DC2_DISK_PRI];
  assign disk_secondary_enable = st.regs.decode_control_two[idc_pkg::DC2_DISK_SEC];
  assign general_chip_select_n = st.dec.general_chip_select_n;
  assign isa_irq               = st.isa_irq;

endmodule // idc_top

/* hdl/idc_pkg.sv */
/*
  Constants, register layout and carrier types for the legacy I/O decode,
  PCI interrupt steering and general chip select block.
  Assumes a 32-bit APB slave port and 16-bit I/O addresses from the PCI side.
*/
package idc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DECODE_CONTROL_TWO  = 8'h5B;
  localparam logic [7:0] IDX_PCI_IRQ_STEER_ONE   = 8'h5C;
  localparam logic [7:0] IDX_PCI_IRQ_STEER_TWO   = 8'h5D;
  localparam logic [7:0] IDX_CHIP_SELECT_BASE    = 8'h70;
  localparam logic [7:0] IDX_CHIP_SELECT_CONTROL = 8'h72;

  // Reset values and decode control two write mask
  localparam logic [7:0]  RST_DECODE_CONTROL_TWO  = 8'h20;
  localparam logic [7:0]  RST_PCI_IRQ_STEER       = 8'h00;
  localparam logic [15:0] RST_CHIP_SELECT_BASE    = 16'h0000;
  localparam logic [7:0]  RST_CHIP_SELECT_CONTROL = 8'h00;
  localparam logic [7:0]  DC2_WRITE_MASK          = 8'hBF;

  // Decode control two bit positions
  localparam int DC2_KBD_ALT   = 7;
  localparam int DC2_ROM_POS   = 5;
  localparam int DC2_DISK_SEC  = 4;
  localparam int DC2_DISK_PRI  = 3;
  localparam int DC2_PAR_THREE = 2;
  localparam int DC2_PAR_TWO   = 1;
  localparam int DC2_PAR_ONE   = 0;

  // Chip select control bit positions
  localparam int CSC_ENABLE   = 7;
  localparam int CSC_WRITE_EN = 6;
  localparam int CSC_READ_EN  = 5;
  localparam int CSC_RANGE_HI = 4;

  // Steering codes, field width and line counts
  localparam logic [3:0] STEER_OFF    = 4'h0;
  localparam logic [3:0] STEER_RSVD_A = 4'h2;
  localparam logic [3:0] STEER_RSVD_B = 4'h8;
  localparam logic [3:0] STEER_RSVD_C = 4'hD;
  localparam int         STEER_W      = 4;
  localparam int         NUM_PCI_INT  = 4;
  localparam int         NUM_ISA_IRQ  = 16;

  // Legacy I/O ports
  localparam logic [15:0] KBD_ALT_DATA = 16'h0062;
  localparam logic [15:0] KBD_ALT_CMD  = 16'h0066;
  localparam logic [15:0] DSEC_LO      = 16'h0170;
  localparam logic [15:0] DSEC_HI      = 16'h0177;
  localparam logic [15:0] DSEC_CTL     = 16'h0376;
  localparam logic [15:0] DPRI_LO      = 16'h01F0;
  localparam logic [15:0] DPRI_HI      = 16'h01F7;
  localparam logic [15:0] DPRI_CTL     = 16'h03F6;
  localparam logic [15:0] PAR3_LO      = 16'h0278;
  localparam logic [15:0] PAR3_HI      = 16'h027F;
  localparam logic [15:0] PAR2_LO      = 16'h0378;
  localparam logic [15:0] PAR2_HI      = 16'h037F;
  localparam logic [15:0] PAR1_LO      = 16'h03BC;
  localparam logic [15:0] PAR1_HI      = 16'h03BF;

  typedef struct packed {
    logic [7:0]  decode_control_two;
    logic [7:0]  pci_irq_steering_one;
    logic [7:0]  pci_irq_steering_two;
    logic [15:0] chip_select_base_address;
    logic [7:0]  chip_select_control;
  } idc_regs_t;

  // Registered decode answer for one I/O or ROM cycle
  typedef struct packed {
    logic claim_positive;
    logic claim_subtractive;
    logic isa_forward;
    logic disk_primary_hit;
    logic disk_secondary_hit;
    logic general_chip_select_n;
  } idc_decode_t;

  typedef struct packed {
    idc_regs_t              regs;
    logic [31:0]            prdata;
    idc_decode_t            dec;
    logic [NUM_ISA_IRQ-1:0] isa_irq;
  } idc_state_t;

endpackage

/* tb/idc_chk.sv */
/* Assertions on the decode and steering ports of idc_top.
   Assumes a bind to idc_top and a single clock domain. */
module idc_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Decode
  input wire logic        io_valid,
  input wire logic [15:0] io_addr,
  input wire logic        rom_space_hit,
  input wire logic        claim_positive,
  input wire logic        claim_subtractive,
  input wire logic        isa_forward,
  input wire logic        disk_primary_hit,
  input wire logic        disk_primary_enable,
  input wire logic        general_chip_select_n,
  // Interrupts
  input wire logic [3:0]  pci_int_n,
  input wire logic [15:0] isa_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic alias_hit, pri_hit, par_hit;
  assign alias_hit = io_addr inside {[16'h07BC:16'h07BE], [16'h0678:16'h067A], [16'h0778:16'h077A]};
  assign pri_hit = io_addr inside {[16'h01F0:16'h01F7], 16'h03F6};
  assign par_hit = io_addr inside {[16'h0278:16'h027F], [16'h0378:16'h037F], [16'h03BC:16'h03BF]};
  sequence s_io; io_valid && !rom_space_hit; endsequence
  a_idle_quiet: assert property (!io_valid |=> !claim_positive && !claim_subtractive
    && general_chip_select_n) else $error("outputs active without a cycle");
  a_claim_excl: assert property (io_valid |=> claim_positive != claim_subtractive)
    else $error("claim outputs not exclusive");
  a_alias_sub: assert property (s_io ##0 alias_hit |=>
    claim_subtractive && isa_forward) else $error("alias range not subtractive");
  a_disk_claim: assert property (s_io ##0 pri_hit && disk_primary_enable |=>
    disk_primary_hit && claim_positive && !isa_forward) else $error("disk not claimed");
  a_disk_fwd: assert property (s_io ##0 pri_hit && !disk_primary_enable |=>
    !disk_primary_hit && claim_subtractive && isa_forward) else $error("disk not forwarded");
  a_par_fwd: assert property (s_io ##0 par_hit |=> isa_forward)
    else $error("parallel range not on isa");
  a_rom_no_cs: assert property (io_valid && rom_space_hit |=> general_chip_select_n)
    else $error("chip select on rom cycle");
  a_irq_quiet: assert property (pci_int_n == 4'hF |=> isa_irq == 16'h0000)
    else $error("irq without pci request");
  a_irq_rsvd: assert property (!(isa_irq[0] || isa_irq[2] || isa_irq[8] || isa_irq[13]))
    else $error("reserved irq driven");
endmodule // idc_chk

/* tb/idc_pci_init.sv */
/* PCI initiator model: presents one I/O or ROM cycle per bench request.
   Assumes requests {valid, write, rom, address} change just after mclk rises. */
module idc_pci_init (
  // Clock, reset, request and presented cycle
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [18:0] req,
  output logic      [18:0] cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released write and address lines invert and valid and rom drop, so a stale address never reads as a live one
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) cyc <= 19'h00000;
    else if (req[18]) cyc <= req;
    else cyc <= {1'b0, ~cyc[17], 1'b0, ~cyc[15:0]};
  end
endmodule // idc_pci_init

/* tb/idc_top_tb_top.sv */
/* Self-checking bench for idc_top: APB tasks, initiator model, queued checks.
   Assumes idc_chk and idc_pci_init are compiled before it. */
module idc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] RA [6] = '{12'h16C, 12'h170, 12'h174, 12'h1C0, 12'h1C8, 12'h200};
  localparam logic [15:0] AT [22] = '{16'h0062, 16'h0066, 16'h01F0, 16'h01F7, 16'h03F6,
    16'h0170, 16'h0177, 16'h0376, 16'h0278, 16'h027F, 16'h07BC, 16'h07BE, 16'h0378,
    16'h037F, 16'h0678, 16'h067A, 16'h03BC, 16'h03BF, 16'h0778, 16'h077A, 16'h0060, 16'h01F8};
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, kbp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [15:0] isa_irq, base;
  logic [18:0] req, cyc;
  logic [7:0]  dc2, ctl, st1, st2;
  logic [5:0]  dec;
  logic [1:0]  den;
  logic [3:0]  pci_int_n, strb;
  logic [33:0] exp_b, apb_q [$];
  logic [11:0] exp_d, dec_q [$];
  int          err_total, checks, cyc_n;

  idc_pci_init u_init (.mclk(mclk), .reset(reset), .req(req), .cyc(cyc));
  idc_top dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_valid(cyc[18]), .io_write(cyc[17]), .io_addr(cyc[15:0]),
    .rom_space_hit(cyc[16]), .keyboard_positive(kbp), .claim_positive(dec[5]),
    .claim_subtractive(dec[4]), .isa_forward(dec[3]), .disk_primary_hit(dec[2]),
    .disk_secondary_hit(dec[1]), .disk_primary_enable(den[0]),
    .disk_secondary_enable(den[1]), .general_chip_select_n(dec[0]),
    .pci_int_n(pci_int_n), .isa_irq(isa_irq));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Care mask in the upper six bits, expected outputs in the lower six
  function automatic logic [11:0] dexp(input logic wr, rom, input logic [15:0] a);
    logic [15:0] m;
    logic        p, f, h1, h2, sel;
    m = {11'h000, ctl[4:0]};
    {p, f, h1, h2} = 4'b0100;
    if (rom) {p, f} = {dc2[5], 1'b0};
    else if (a inside {[16'h01F0:16'h01F7], 16'h03F6}) {p, f, h1} = {dc2[3], !dc2[3], dc2[3]};
    else if (a inside {[16'h0170:16'h0177], 16'h0376}) {p, f, h2} = {dc2[4], !dc2[4], dc2[4]};
    else if (dc2[7] && a inside {16'h0062, 16'h0066}) p = kbp;
    else if (a inside {[16'h0278:16'h027F]}) p = dc2[2];
    else if (a inside {[16'h0378:16'h037F]}) p = dc2[1];
    else if (a inside {[16'h03BC:16'h03BF]}) p = dc2[0];
    sel = ctl[7] && !rom && (wr ? ctl[6] : ctl[5]) && ((a & ~m) == (base & ~m));
    return {2'b11, !rom, 3'b111, p, !p, f, h1, h2, !sel};
  endfunction

  function automatic logic [15:0] iexp(input logic [15:0] s, input logic [3:0] n);
    logic [3:0] c;
    iexp = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      c = s[4*i +: 4];
      if (!n[i] && !(c inside {4'h0, 4'h2, 4'h8, 4'hD})) iexp[c] = 1'b1;
    end
  endfunction

  task automatic tally(input logic [33:0] got, exp, care, input string what);
    checks++;
    if (((got ^ exp) & care) !== 34'h0) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, e);
    apb_q.push_back({wr, !(a inside {RA[0], RA[1], RA[2], RA[3], RA[4]}), e});
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d, e);
    apb(1'b1, a, d, 32'h0);
    apb(1'b0, a, 32'h0, e);
  endtask

  task automatic io(input logic wr, rom, input logic [15:0] a);
    dec_q.push_back(dexp(wr, rom, a));
    req <= {1'b1, wr, rom, a};
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      err_total++;
      $display("ERROR %0t timeout", $time);
      close_out;
    end
    if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
      exp_b = apb_q.pop_front();
      tally({exp_b[33], pslverr, prdata}, exp_b, {2'b01, {32{!exp_b[33]}}}, "bus");
    end
    if (dec[5:4] !== 2'b00 && !reset) begin
      exp_d = dec_q.size() > 0 ? dec_q.pop_front() : 12'hFFF;
      tally(34'(dec), 34'(exp_d[5:0]), 34'(exp_d[11:6]), "decode");
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, req, kbp} = '0;
    {dc2, ctl, base, pci_int_n} = {8'h20, 8'h00, 16'h0000, 4'hF};
    strb = 4'hF;
    lfsr = 32'h45F9425E;
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    foreach (RA[i]) apb(1'b0, RA[i], 32'h0, i == 0 ? 32'h20 : 32'h0);
    apb(1'b1, 12'h178, 32'hFFFFFFFF, 32'h0);
    // Upper byte lane alone reaches the base register
    strb <= 4'h2;
    apb(1'b1, 12'h1C0, 32'h0000A55A, 32'h0);
    strb <= 4'hF;
    apb(1'b0, 12'h1C0, 32'h0, 32'h0000A500);
    for (int k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      kbp <= lfsr[9];
      dc2 = k == 0 ? 8'h20 : k == 1 ? 8'hFF : k == 2 ? 8'h00 : lfsr[7:0];
      wreg(12'h16C, {24'h0, dc2}, {24'h0, dc2 & 8'hBF});
      dc2 &= 8'hBF;
      base = lfsr[31:16];
      ctl = {k != 0, k == 0 ? 2'b11 : 2'(k), lfsr[14:10]};
      wreg(12'h1C0, {16'h0, base}, {16'h0, base});
      wreg(12'h1C8, {24'h0, ctl}, {24'h0, ctl});
      tally(34'(den), 34'({dc2[4], dc2[3]}), 34'h3, "disk enable");
      foreach (AT[i]) begin
        lfsr = nxt(lfsr);
        io(lfsr[0], 1'b0, AT[i]);
      end
      io(1'b0, 1'b1, base);
      for (int w = 0; w < 2; w++) begin
        io(w[0], 1'b0, base);
        io(w[0], 1'b0, base | 16'(ctl[4:0]));
        io(w[0], 1'b0, (base | 16'(ctl[4:0])) + 16'h1);
        io(w[0], 1'b0, (base & ~16'(ctl[4:0])) - 16'h1);
      end
      req <= 19'h00000;
      repeat (4) @(posedge mclk);
    end
    for (int c = 0; c < 16; c++) begin
      lfsr = nxt(lfsr);
      st1 = {4'(c), 4'(15 - c)};
      st2 = lfsr[23:16];
      // Targets are taken as level sensitive, so lines share an IRQ by OR
      wreg(12'h170, {24'h0, st1}, {24'h0, st1});
      wreg(12'h174, {24'h0, st2}, {24'h0, st2});
      pci_int_n <= lfsr[3:0];
      repeat (3) @(posedge mclk);
      tally(34'(isa_irq), 34'(iexp({st2, st1}, pci_int_n)), 34'hFFFF, "irq");
    end
    tally(34'(dec_q.size()), 34'h0, 34'h3FF, "missing decode");
    close_out;
  end
endmodule // idc_top_tb_top

bind idc_top idc_chk u_chk (.mclk(mclk), .reset(reset), .io_valid(io_valid),
  .io_addr(io_addr), .rom_space_hit(rom_space_hit), .claim_positive(claim_positive),
  .claim_subtractive(claim_subtractive), .isa_forward(isa_forward),
  .disk_primary_hit(disk_primary_hit), .disk_primary_enable(disk_primary_enable),
  .general_chip_select_n(general_chip_select_n), .pci_int_n(pci_int_n), .isa_irq(isa_irq));
